// ### hw/dual_irq_ctrl.sv
// Interrupt controller of one processor subsystem with Wishbone registers.
// Assumes same-clock event pulses and an async active-low pin group.
//
// Summary of operation
// R01 - Reset vectors to 00, priority 1; non-maskable to 04, priority 2.
// R02 - Slots four words apart from base; software 17-30 at 08-3C.
// R03 - External pin 0 vectors to 40, priority 3.
// R04 - External pin 1 to 44, priority 4; timer to 4C, priority 6.
// R05 - Serial port 0 receive vectors to 50, priority 7.
// R06 - Serial port 0 transmit vectors to 54, priority 8.
// R07 - Vector 58 serial 2 receive or DMA0; 5C serial 2 other or DMA1.
// R08 - Host port interrupt vectors to 64, priority 12, from host bit.
// R09 - Serial port 1 receive or DMA2 share vector 68, priority 13.
// R10 - Serial 1 transmit or DMA3 at 6C; DMA4 at 70; DMA5 at 74.
// R11 - Interprocessor interrupt vectors to 78, priority 17.
// R12 - Incoming interprocessor interrupt latches into flag bit 14.
// R13 - Writing one to request field raises an interprocessor interrupt.
// R14 - Software clears the request field with zero before another request.
// R15 - Request from either subsystem sets the flag on the other.
// R16 - Upper byte: 15 reserved, 14 interprocessor, 13-9 sources, 8 reserved.
// R17 - Lower byte: 7-3 sources, 2 reserved, 1 pin 1, 0 pin 0.
// R18 - Flag one means pending; mask one means enabled, zero masked.
// R19 - Among pending unmasked interrupts the lowest priority number wins.
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module dual_irq_ctrl
  import dual_irq_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire irq_events_t       events_i,
  input  wire logic              ext_pin0_irq_b_i,
  input  wire logic              ext_pin1_irq_b_i,
  input  wire logic              nmi_b_i,
  input  wire logic              interprocessor_irq_i,
  output logic                   interprocessor_request_o,
  input  wire logic              int_ack_i,
  output svc_offer_t             offer_o,
  output logic                   irq_o
);

  if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
    $error("dual_irq_ctrl needs ADDR_W between 5 and 8");
  end

  // Byte-lane merge of a 16-bit register field
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] din,
                                          input logic [1:0]  sel);
    merge16[7:0]  = sel[0] ? din[7:0]  : old[7:0];
    merge16[15:8] = sel[1] ? din[15:8] : old[15:8];
  endfunction

  // Relative slot of a served source
  function automatic logic [6:0] slot_of(input svc_kind_t kind,
                                         input logic [3:0] idx);
    case (kind)
      KIND_RESET: slot_of = VEC_RESET;
      KIND_NMI:   slot_of = VEC_NMI;
      KIND_SOFT:  slot_of = VEC_SOFT0 + {1'b0, idx, 2'b00};    // [R02]
      KIND_MASK:  slot_of = VEC_MASK0 + {1'b0, idx, 2'b00};
      default:    slot_of = VEC_RESET;
    endcase
  endfunction

  logic [15:0]   mask_r;
  logic [15:0]   flag_r;
  logic [15:0]   flag_nxt;
  logic          bsc_req_r;
  logic [8:0]    vbase_r;
  logic [3:0]    srcsel_r;
  logic [13:0]   soft_r;
  logic [13:0]   soft_nxt;
  logic          reset_pend_r;
  logic          nmi_pend_r;
  logic          ipi_in_d_r;
  logic          wb_hit;
  logic          wr_stb;
  logic [7:0]    adr8;
  logic          pin0_fall;
  logic          pin1_fall;
  logic          nmi_fall;
  logic [15:0]   set_bits;
  logic [15:0]   clr_bits;
  logic [15:0]   armed;
  logic          mask_hit;
  logic [3:0]    mask_idx;
  logic          soft_hit;
  logic [3:0]    soft_idx;
  logic [4:0]    soft_num;
  svc_state_t    state_r;
  svc_kind_t     kind_r;
  logic [3:0]    idx_r;
  svc_kind_t     pick_kind;
  logic [3:0]    pick_idx;
  logic          pick_any;
  logic [4:0]    pick_prio;
  logic [31:0]   rd_data;

  assign adr8   = 8'(wb_adr_i);
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master samples ack high
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

  irq_pin_sync u_pin0 (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .pin_b_i    (ext_pin0_irq_b_i),
    .fall_o     (pin0_fall)
  );

  irq_pin_sync u_pin1 (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .pin_b_i    (ext_pin1_irq_b_i),
    .fall_o     (pin1_fall)
  );

  irq_pin_sync u_nmi (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .pin_b_i    (nmi_b_i),
    .fall_o     (nmi_fall)
  );

  // Event routing into the shared flag layout
  always_comb begin
    set_bits            = '0;
    set_bits[BIT_PIN0]  = pin0_fall;                            // [R03]
    set_bits[BIT_PIN1]  = pin1_fall;                            // [R04]
    set_bits[BIT_TIMER] = events_i.timer;                       // [R04]
    set_bits[BIT_SP0RX] = events_i.sport0_rx;                   // [R05]
    set_bits[BIT_SP0TX] = events_i.sport0_tx;                   // [R06]
    set_bits[BIT_SH58]  = srcsel_r[0] ? events_i.dma_ch0
                                      : events_i.sport2_rx;     // [R07]
    set_bits[BIT_SH5C]  = srcsel_r[1] ? events_i.dma_ch1
                                      : events_i.sport2_tx;     // [R07]
    set_bits[BIT_HOST]  = events_i.host_to_core;                // [R08]
    set_bits[BIT_SH68]  = srcsel_r[2] ? events_i.dma_ch2
                                      : events_i.sport1_rx;     // [R09]
    set_bits[BIT_SH6C]  = srcsel_r[3] ? events_i.dma_ch3
                                      : events_i.sport1_tx;     // [R10]
    set_bits[BIT_DMA4]  = events_i.dma_ch4;                     // [R10]
    set_bits[BIT_DMA5]  = events_i.dma_ch5;                     // [R10]
    // Only a rising request counts, so the far side must drop it first
    set_bits[BIT_IPI] = interprocessor_irq_i && !ipi_in_d_r; // [R12] [R15]
  end

  always_comb begin
    clr_bits = '0;
    if (wr_stb && adr8 == OFF_FLAG) begin
      clr_bits = merge16(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
    if (state_r == SVC_OFFER && int_ack_i && kind_r == KIND_MASK) begin
      clr_bits[idx_r] = 1'b1;
    end
  end

  // Set beats clear so an event in the clearing cycle is kept
  assign flag_nxt = ((flag_r & ~clr_bits) | set_bits) & IMPL_BITS; // [R16]

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_r     <= FLAG_RST;
      ipi_in_d_r <= 1'b0;
    end else begin
      flag_r     <= flag_nxt;                                   // [R18]
      ipi_in_d_r <= interprocessor_irq_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_r <= MASK_RST;
    end else if (wr_stb && adr8 == OFF_MASK) begin
      mask_r <= merge16(mask_r, wb_dat_i[15:0], wb_sel_i[1:0])
                & IMPL_BITS;                                    // [R16] [R17]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bsc_req_r <= 1'b0;
    end else if (wr_stb && adr8 == OFF_BSC && wb_sel_i[0]) begin
      bsc_req_r <= wb_dat_i[BSC_REQ_BIT];                       // [R13]
    end
  end

  // The request level goes straight to the other subsystem
  assign interprocessor_request_o = bsc_req_r;                  // [R15]

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vbase_r  <= VBASE_RST;
      srcsel_r <= SRCSEL_RST;
    end else begin
      if (wr_stb && adr8 == OFF_VBASE) begin
        vbase_r <= 9'(merge16({7'h00, vbase_r}, wb_dat_i[15:0],
                              wb_sel_i[1:0]));
      end
      if (wr_stb && adr8 == OFF_SRCSEL && wb_sel_i[0]) begin
        srcsel_r <= wb_dat_i[3:0];
      end
    end
  end

  // Software interrupt requests, numbers outside 17..30 are ignored
  assign soft_num = wb_dat_i[4:0];

  always_comb begin
    soft_nxt = soft_r;
    if (state_r == SVC_OFFER && int_ack_i && kind_r == KIND_SOFT) begin
      soft_nxt[idx_r] = 1'b0;
    end
    if (wr_stb && adr8 == OFF_SOFT && wb_sel_i[0] &&
        soft_num >= SOFT_FIRST && soft_num <= SOFT_LAST) begin
      soft_nxt[4'(soft_num - SOFT_FIRST)] = 1'b1;               // [R02]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      soft_r <= '0;
    end else begin
      soft_r <= soft_nxt;
    end
  end

  // Hardware or software reset is served first after release
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reset_pend_r <= 1'b1;
    end else if (wr_stb && adr8 == OFF_CTRL && wb_sel_i[0] &&
                 wb_dat_i[CTRL_SWRST_BIT]) begin
      reset_pend_r <= 1'b1;                                     // [R01]
    end else if (state_r == SVC_OFFER && int_ack_i &&
                 kind_r == KIND_RESET) begin
      reset_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_fall) begin
      nmi_pend_r <= 1'b1;
    end else if (state_r == SVC_OFFER && int_ack_i &&
                 kind_r == KIND_NMI) begin
      nmi_pend_r <= 1'b0;
    end
  end

  // Maskable bits rise in priority number with their bit position
  assign armed = flag_r & mask_r & IMPL_BITS;                   // [R18]

  irq_lowest_bit #(
    .W (16)
  ) u_mask_pick (
    .req_i (armed),
    .hit_o (mask_hit),
    .idx_o (mask_idx)
  );

  irq_lowest_bit #(
    .W (SOFT_NUM)
  ) u_soft_pick (
    .req_i (soft_r),
    .hit_o (soft_hit),
    .idx_o (soft_idx)
  );

  always_comb begin
    pick_any  = 1'b1;
    pick_kind = KIND_RESET;
    pick_idx  = 4'h0;
    pick_prio = PRIO_RESET;
    if (reset_pend_r) begin
      pick_kind = KIND_RESET;                                   // [R01]
    end else if (nmi_pend_r) begin
      pick_kind = KIND_NMI;                                     // [R01]
      pick_prio = PRIO_NMI;
    end else if (soft_hit) begin
      pick_kind = KIND_SOFT;
      pick_idx  = soft_idx;
      pick_prio = PRIO_SOFT;
    end else if (mask_hit) begin
      pick_kind = KIND_MASK;                                    // [R19]
      pick_idx  = mask_idx;
      pick_prio = PRIO_MASK0 + {1'b0, mask_idx};                // [R11]
    end else begin
      pick_any  = 1'b0;
    end
  end

  // Offer one vector, hold it until acknowledged, then rest two cycles (done, idle)
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= SVC_IDLE;
      kind_r  <= KIND_RESET;
      idx_r   <= 4'h0;
      offer_o <= '0;
    end else begin
      case (state_r)
        SVC_IDLE: begin
          if (pick_any) begin
            state_r      <= SVC_OFFER;
            kind_r       <= pick_kind;
            idx_r        <= pick_idx;
            offer_o.req  <= 1'b1;
            offer_o.addr <= {vbase_r,
                             slot_of(pick_kind, pick_idx)};     // [R02]
            offer_o.prio <= pick_prio;
          end
        end
        SVC_OFFER: begin
          if (int_ack_i) begin
            state_r     <= SVC_DONE;
            offer_o.req <= 1'b0;
          end
        end
        SVC_DONE: begin
          state_r <= SVC_IDLE;
        end
        default: begin
          state_r     <= SVC_IDLE;
          offer_o.req <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flag_nxt & mask_r);                            // [R18]
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (adr8)
      OFF_MASK:   rd_data[15:0] = mask_r;
      OFF_FLAG:   rd_data[15:0] = flag_r;
      OFF_BSC:    rd_data[BSC_REQ_BIT] = bsc_req_r;
      OFF_VBASE:  rd_data[8:0] = vbase_r;
      OFF_SRCSEL: rd_data[3:0] = srcsel_r;
      OFF_SOFT:   rd_data[13:0] = soft_r;
      OFF_STATUS: rd_data = {6'h00, nmi_pend_r, reset_pend_r,
                             state_r, offer_o.prio, offer_o.addr};
      default:    rd_data = 32'h0000_0000;
    endcase
  end

  // One wait state; unmapped offsets answer with zero
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_data : 32'h0000_0000;
    end
  end

endmodule

// ### hw/dual_irq_pkg.sv
// Constants, field layout and carrier types for the subsystem interrupt
// controller. Assumes one controller per processor subsystem.
package dual_irq_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] OFF_MASK   = 8'h00;
  localparam logic [7:0] OFF_FLAG   = 8'h04;
  localparam logic [7:0] OFF_BSC    = 8'h08;
  localparam logic [7:0] OFF_VBASE  = 8'h0C;
  localparam logic [7:0] OFF_SRCSEL = 8'h10;
  localparam logic [7:0] OFF_SOFT   = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_CTRL   = 8'h1C;

  // Shared bit layout of interrupt_mask and interrupt_flag
  localparam int BIT_PIN0  = 0;
  localparam int BIT_PIN1  = 1;
  localparam int BIT_TIMER = 3;
  localparam int BIT_SP0RX = 4;
  localparam int BIT_SP0TX = 5;
  localparam int BIT_SH58  = 6;
  localparam int BIT_SH5C  = 7;
  localparam int BIT_HOST  = 9;
  localparam int BIT_SH68  = 10;
  localparam int BIT_SH6C  = 11;
  localparam int BIT_DMA4  = 12;
  localparam int BIT_DMA5  = 13;
  localparam int BIT_IPI   = 14;
  // Bits 15, 8 and 2 are reserved and read zero
  localparam logic [15:0] IMPL_BITS = 16'h7EFB;

  localparam logic [15:0] MASK_RST   = 16'h0000;
  localparam logic [15:0] FLAG_RST   = 16'h0000;
  localparam logic [8:0]  VBASE_RST  = 9'h000;
  localparam logic [3:0]  SRCSEL_RST = 4'h0;

  localparam int BSC_REQ_BIT    = 0;
  localparam int CTRL_SWRST_BIT = 0;

  // Vector-relative locations, slots four words apart
  localparam logic [6:0] VEC_RESET = 7'h00;
  localparam logic [6:0] VEC_NMI   = 7'h04;
  localparam logic [6:0] VEC_SOFT0 = 7'h08;
  localparam logic [6:0] VEC_MASK0 = 7'h40;
  localparam logic [4:0] SOFT_FIRST = 5'd17;
  localparam logic [4:0] SOFT_LAST  = 5'd30;
  localparam int         SOFT_NUM   = 14;

  localparam logic [4:0] PRIO_RESET = 5'd1;
  localparam logic [4:0] PRIO_NMI   = 5'd2;
  localparam logic [4:0] PRIO_SOFT  = 5'd0;
  localparam logic [4:0] PRIO_MASK0 = 5'd3;

  typedef struct packed {
    logic timer;
    logic sport0_rx;
    logic sport0_tx;
    logic sport1_rx;
    logic sport1_tx;
    logic sport2_rx;
    logic sport2_tx;
    logic dma_ch0;
    logic dma_ch1;
    logic dma_ch2;
    logic dma_ch3;
    logic dma_ch4;
    logic dma_ch5;
    logic host_to_core;
  } irq_events_t;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
    logic [4:0]  prio;
  } svc_offer_t;

  typedef enum logic [2:0] {
    SVC_IDLE  = 3'b001,
    SVC_OFFER = 3'b010,
    SVC_DONE  = 3'b100
  } svc_state_t;

  typedef enum logic [1:0] {
    KIND_RESET = 2'd0,
    KIND_NMI   = 2'd1,
    KIND_SOFT  = 2'd2,
    KIND_MASK  = 2'd3
  } svc_kind_t;

endpackage

// ### hw/irq_lowest_bit.sv
// Finds the lowest set bit of a request vector.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
module irq_lowest_bit #(
  parameter int unsigned W = 16
) (
  input  wire logic [W-1:0]         req_i,
  output logic                      hit_o,
  output logic [$clog2(W)-1:0]      idx_o
);
  if (W < 2) begin : g_chk
    $error("irq_lowest_bit needs W of at least 2");
  end

  always_comb begin
    hit_o = 1'b0;
    idx_o = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        hit_o = 1'b1;
        idx_o = i[$clog2(W)-1:0];
      end
    end
  end
endmodule

// ### hw/irq_pin_sync.sv
// Three-stage synchroniser for an active-low interrupt pin.
// Assumes the pin is asynchronous to core_clk_i; gives a falling-edge pulse.
`timescale 1ns/1ps
module irq_pin_sync (
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  input  wire logic pin_b_i,
  output logic      fall_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= pin_b_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_r <= 1'b1;
      fall_o  <= 1'b0;
    end else begin
      fall_o <= (s2_r == s3_r) && level_r && !s3_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule

// ### tb/dual_irq_ctrl_asserts.sv
// Port checker for the subsystem interrupt controller, bound to its top.
// Assumes classic Wishbone single cycles and one core clock.
`timescale 1ns/1ps
module dual_irq_ctrl_chk
  import dual_irq_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              core_clk_i,
  input wire logic              rst_b_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire irq_events_t       events_i,
  input wire logic              ext_pin0_irq_b_i,
  input wire logic              ext_pin1_irq_b_i,
  input wire logic              nmi_b_i,
  input wire logic              interprocessor_irq_i,
  input wire logic              interprocessor_request_o,
  input wire logic              int_ack_i,
  input wire svc_offer_t        offer_o,
  input wire logic              irq_o
);
  logic [6:0] slot;
  logic [4:0] pr;
  logic       req_bit;
  assign slot = offer_o.addr[6:0];
  assign pr = offer_o.prio;
  assign req_bit = wb_dat_i[BSC_REQ_BIT];
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_wb_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside acknowledge");
  chk_offer_hold: assert property (
    offer_o.req && !int_ack_i
      |=> offer_o.req && $stable(offer_o.addr) && $stable(offer_o.prio))
    else $error("offer changed before acknowledge");
  chk_ack_takes: assert property (
    offer_o.req && int_ack_i |=> !offer_o.req [*2])
    else $error("offer not withdrawn after acknowledge");
  chk_reset_vec: assert property (
    $rose(rst_b_i) |-> ##[1:3] offer_o.req
      && offer_o.addr == {VBASE_RST, VEC_RESET} && pr == PRIO_RESET)
    else $error("reset vector not offered after reset");
  chk_fixed_slots: assert property (
    offer_o.req && pr < 5'd3
      |-> (pr == PRIO_RESET && slot == VEC_RESET)
       || (pr == PRIO_NMI && slot == VEC_NMI)
       || (pr == PRIO_SOFT && slot inside {[7'h08:7'h3C]}
           && slot[1:0] == 2'b00))
    else $error("reset, nmi or software slot wrong");
  chk_low_slots: assert property (
    offer_o.req && pr >= 5'd3 && pr <= 5'd10
      |-> pr != 5'd5 && slot == VEC_MASK0 + 7'(4 * (pr - 5'd3)))
    else $error("maskable slot does not match priority");
  chk_high_slots: assert property (
    offer_o.req && pr >= 5'd11
      |-> pr <= 5'd17 && pr != 5'd11
       && slot == VEC_MASK0 + 7'(4 * (pr - 5'd3)))
    else $error("upper maskable slot does not match priority");
  chk_ipi_write: assert property (
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_W'(OFF_BSC)
      |=> interprocessor_request_o == $past(req_bit))
    else $error("request output does not follow written field");
  chk_rsvd_bits: assert property (
    wb_ack_o && !wb_we_i && (wb_adr_i == ADDR_W'(OFF_MASK)
      || wb_adr_i == ADDR_W'(OFF_FLAG))
      |-> (wb_dat_o & ~{16'h0000, IMPL_BITS}) == 32'h0000_0000)
    else $error("reserved or upper bits read nonzero");

  cov_serve: cover property (offer_o.req && int_ack_i);
  cov_ipi: cover property (offer_o.req && pr == 5'd17);
  cov_soft: cover property (offer_o.req && pr == PRIO_SOFT);
endmodule

bind dual_irq_ctrl dual_irq_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .events_i(events_i),
  .ext_pin0_irq_b_i(ext_pin0_irq_b_i), .ext_pin1_irq_b_i(ext_pin1_irq_b_i),
  .nmi_b_i(nmi_b_i), .interprocessor_irq_i(interprocessor_irq_i),
  .interprocessor_request_o(interprocessor_request_o),
  .int_ack_i(int_ack_i), .offer_o(offer_o), .irq_o(irq_o)
);

// ### tb/dual_irq_ctrl_tb.sv
// Self-checking bench for the subsystem interrupt controller.
// Assumes the peer model on the interprocessor path and the bound checker.
`timescale 1ns/1ps
module dual_irq_ctrl_tb
  import dual_irq_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic        cyc, stb, we, ack, ack_in, nmi_b, send, ipi_in, ipi_out, irq;
  logic [1:0]  pins_b;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, dat_o;
  logic [8:0]  vb;
  irq_events_t ev;
  svc_offer_t  offer;
  int          n_fail = 0;
  int          n_compared = 0;
  int          peer_seen;
  int          bt[14] = '{3, 4, 5, 10, 11, 6, 7, 6, 7, 10, 11, 12, 13, 9};

  dual_irq_ctrl #(.ADDR_W(8)) dut (
    .core_clk_i(clk), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .events_i(ev),
    .ext_pin0_irq_b_i(pins_b[0]), .ext_pin1_irq_b_i(pins_b[1]),
    .nmi_b_i(nmi_b), .interprocessor_irq_i(ipi_in),
    .interprocessor_request_o(ipi_out), .int_ack_i(ack_in),
    .offer_o(offer), .irq_o(irq)
  );
  ipi_peer_model peer (
    .core_clk_i(clk), .rst_b_i(rst_b), .peer_req_i(ipi_out),
    .send_i(send), .ipi_o(ipi_in), .n_seen_o(peer_seen)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One classic cycle; held until acknowledge is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    // One wait state is assumed; only the watchdog ends a missing answer
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1);
    // Request seen at the first edge, ack sampled high at the second
    check(32'(k), 32'h0000_0002);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    check(rdat, e);
  endtask

  // Waits for the offer, checks it, then acknowledges it for one cycle
  task automatic serve(input logic [15:0] a, input logic [4:0] p);
    int k;
    for (k = 0; k < 40; k++) begin
      @(negedge clk);
      if (offer.req === 1'b1) break;
    end
    check(32'(offer.req), 32'h0000_0001);
    check(32'(offer.addr), 32'(a));
    check(32'(offer.prio), 32'(p));
    @(posedge clk);
    ack_in <= 1'b1;
    @(posedge clk);
    ack_in <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= '0;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Whole run is a few hundred cycles; this bound is far beyond it
  initial begin
    #200_000;
    n_fail++;
    end_of_test();
  end

  initial begin
    int i;
    rst_b = 1'b0;
    {cyc, stb, we, ack_in, send} = '0;
    {adr, sel, wdat, ev} = '0;
    pins_b = 2'b11;
    nmi_b = 1'b1;
    vb = 9'h1A5;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    serve({VBASE_RST, VEC_RESET}, PRIO_RESET);
    rchk(OFF_MASK, 32'(MASK_RST));
    rchk(OFF_FLAG, 32'(FLAG_RST));
    wb(1'b1, OFF_MASK, 32'hFFFF_FFFF);
    rchk(OFF_MASK, 32'(IMPL_BITS));
    rchk(8'h20, 32'h0000_0000);
    wb(1'b1, OFF_VBASE, 32'(vb));
    // Every events_i source, shared slots once each way
    for (i = 0; i < 14; i++) begin
      wb(1'b1, OFF_SRCSEL, (i > 6 && i < 11) ? 32'h0000_000F : 32'h0000_0000);
      pulse(13 - i);
      rchk(OFF_FLAG, 32'h0000_0001 << bt[i]);
      check(32'(irq), 32'h0000_0001);
      serve({vb, 7'(VEC_MASK0 + 4 * bt[i])}, 5'(3 + bt[i]));
      rchk(OFF_FLAG, 32'h0000_0000);
    end
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      pins_b[i] <= 1'b0;
      serve({vb, 7'(VEC_MASK0 + 4 * i)}, 5'(3 + i));
      pins_b <= 2'b11;
    end
    @(posedge clk);
    nmi_b <= 1'b0;
    serve({vb, VEC_NMI}, PRIO_NMI);
    nmi_b <= 1'b1;
    wb(1'b1, OFF_MASK, 32'h0000_0000);
    pulse(1);
    pulse(13);
    check(32'(irq), 32'h0000_0000);
    rchk(OFF_FLAG, 32'h0000_2008);
    wb(1'b1, OFF_MASK, 32'h0000_FFFF);
    serve({vb, 7'h4C}, 5'd6);
    serve({vb, 7'h74}, 5'd16);
    wb(1'b1, OFF_MASK, 32'h0000_0000);
    pulse(13);
    wb(1'b1, OFF_FLAG, 32'h0000_0008);
    rchk(OFF_FLAG, 32'h0000_0000);
    for (i = 17; i <= 30; i++) begin
      wb(1'b1, OFF_SOFT, 32'(i));
      serve({vb, 7'(VEC_SOFT0 + 4 * (i - 17))}, PRIO_SOFT);
    end
    wb(1'b1, OFF_MASK, 32'h0000_4000);
    wb(1'b1, OFF_BSC, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check(32'(peer_seen), 32'h0000_0001);
    send <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(OFF_FLAG, 32'h0000_4000);
    serve({vb, 7'h78}, 5'd17);
    send <= 1'b0;
    wb(1'b1, OFF_BSC, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check(32'(peer_seen), 32'h0000_0001);
    wb(1'b1, OFF_BSC, 32'h0000_0000);
    wb(1'b1, OFF_BSC, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check(32'(peer_seen), 32'h0000_0002);
    wb(1'b1, OFF_VBASE, 32'h0000_0000);
    wb(1'b1, OFF_CTRL, 32'h0000_0001);
    serve({VBASE_RST, VEC_RESET}, PRIO_RESET);
    end_of_test();
  end
endmodule

// ### tb/ipi_peer_model.sv
// Model of the other subsystem on the interprocessor request path.
// Assumes the same core clock and reset as the controller under test.
`timescale 1ns/1ps
module ipi_peer_model (
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  input  wire logic peer_req_i,
  input  wire logic send_i,
  output logic      ipi_o,
  output int        n_seen_o
);
  logic req_d_r;
  // Own request field: a level held until software writes zero
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ipi_o <= 1'b0;
    end else begin
      ipi_o <= send_i;
    end
  end
  // Only a rising request counts, so a held level is one interrupt
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_d_r <= 1'b0;
      n_seen_o <= 0;
    end else begin
      req_d_r <= peer_req_i;
      if (peer_req_i && !req_d_r) begin
        n_seen_o <= n_seen_o + 1;
      end
    end
  end
endmodule
